// >>> io_parameter_block.sv
// parameter store, decode and frequency/period measurement for the io block
// Overview of operation
// - set 0 byte 0 enables channel diagnostics, byte 3 module alarm; reset 0.
// - wire-break enable per analog input, effective only in live-zero current range.
// - universal inputs one and two use: plain, alarm or counter; default plain.
// - universal input three also accepts frequency metering and period counting.
// - process alarm bit; forced on in alarm use, optional in counter use.
// - edge bit selects rising or falling, unused in plain digital use.
// - input three edge applies only in alarm or counter use.
// - direction bit selects up or down, only in counter use.
// - input three gate time codes 0.1 s, 1 s, 10 s in frequency use.
// - input four plain or alarm only; alarm forced off or on accordingly.
// - cycle time code 0 is 16 ms, 1 continuous, 6 upward 3 ms plus steps.
// - analog byte holds type (default voltage) and range (default bipolar voltage).
// - cycle-end alarm enable honoured only when cycle time is not continuous.
// - the four cycle-end alarm enables are ORed into one.
// - frequency use counts rising edges per gate and restarts at once.
// - period use counts 0.5 us ticks between rising edges; all ones is overflow.
// - frequency result reads all ones until the first gate period completes.
`timescale 1ns/100ps
module io_parameter_block #(
	parameter int GATE_0_CYCLES = io_param_pkg::GATE_0_CYCLES,
	parameter int GATE_1_CYCLES = io_param_pkg::GATE_1_CYCLES,
	parameter int GATE_2_CYCLES = io_param_pkg::GATE_2_CYCLES
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// register port
	input wire logic [io_param_pkg::ADDR_W-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// universal input three pin
	input wire logic UNIVERSAL_INPUT_THREE,
	// decoded universal input controls, three-bit use code and one bit of each other control per input
	output logic [11:0] UI_USE,
	output logic [3:0] UI_ALARM_EN,
	output logic [3:0] UI_EDGE_FALLING,
	output logic [3:0] UI_COUNT_DOWN,
	// decoded analog controls
	output logic [3:0] AI_ACTIVE,
	output logic [3:0] AI_DIAG_EN,
	output logic [3:0] AI_WIREBREAK_EN,
	output logic AO_DIAG_EN,
	output logic MODULE_DIAG_ALARM_EN,
	output logic CYCLE_END_ALARM_EN,
	output logic CONTINUOUS_CONVERSION,
	output logic [15:0] CYCLE_TIME_US,
	// measurement results
	output logic [23:0] FREQ_COUNT,
	output logic FREQ_VALID,
	output logic [23:0] PERIOD_COUNT
);
	logic [7:0] channel_diag_enables;
	logic [7:0] wirebreak_diag_enables;
	logic [7:0] module_diag_alarm_enable;
	logic [7:0] universal_cfg [4];
	logic [7:0] analog_cycle_time;
	logic [7:0] analog_cfg [4];
	logic [7:0] analog_input4_range;
	logic [7:0] idx;
	logic [3:0] cea;
	logic [1:0] gate_code;
	logic [2:0] use_three;
	logic [31:0] next_rdata;
	logic meas_freq;
	logic meas_period;
	logic [2:0] pin_sync;
	logic rise;
	logic [31:0] gate_cnt;
	logic [31:0] gate_len;
	logic [23:0] edge_cnt;
	logic [$clog2(io_param_pkg::TICK_CYCLES+1)-1:0] tick_cnt;
	logic [23:0] period_cnt;
	io_param_pkg::meas_state_t period_state;
	logic [3:0] range_sel [4];

	assign idx = ADDR[io_param_pkg::ADDR_W-1:2];

	// parameter set 0 writes
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			channel_diag_enables <= io_param_pkg::ZERO_RESET;
			wirebreak_diag_enables <= io_param_pkg::ZERO_RESET;
			module_diag_alarm_enable <= io_param_pkg::ZERO_RESET;
		end else if (WR) begin
			if (idx == io_param_pkg::IDX_CHANNEL_DIAG)
				channel_diag_enables <= {3'h0, WDATA[4:0]};
			if (idx == io_param_pkg::IDX_WIREBREAK_DIAG)
				wirebreak_diag_enables <= {4'h0, WDATA[3:0]};
			if (idx == io_param_pkg::IDX_MODULE_DIAG)
				module_diag_alarm_enable <= {7'h00, WDATA[0]};
		end
	end

	// parameter set 1 writes
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			for (int i = 0; i < 4; i++) begin
				universal_cfg[i] <= io_param_pkg::ZERO_RESET;
				analog_cfg[i] <= io_param_pkg::ANALOG_RESET;
			end
			analog_cycle_time <= io_param_pkg::CYC_16MS;
			analog_input4_range <= io_param_pkg::ANALOG_RESET;
		end else if (WR) begin
			for (int i = 0; i < 4; i++) begin
				if (idx == io_param_pkg::SET1_BASE + io_param_pkg::IDX_UNIVERSAL1 + 8'(i))
					universal_cfg[i] <= WDATA[7:0];
				if (idx == io_param_pkg::SET1_BASE + io_param_pkg::IDX_ANALOG1 + 8'(i))
					analog_cfg[i] <= WDATA[7:0];
			end
			if (idx == io_param_pkg::SET1_BASE + io_param_pkg::IDX_CYCLE_TIME)
				analog_cycle_time <= WDATA[7:0];
			if (idx == io_param_pkg::SET1_BASE + io_param_pkg::IDX_ANALOG4_RANGE)
				analog_input4_range <= WDATA[7:0];
		end
	end

	// readback
	always_comb begin
		next_rdata = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (idx == io_param_pkg::SET1_BASE + io_param_pkg::IDX_UNIVERSAL1 + 8'(i))
				next_rdata = {24'h00_0000, universal_cfg[i]};
			if (idx == io_param_pkg::SET1_BASE + io_param_pkg::IDX_ANALOG1 + 8'(i))
				next_rdata = {24'h00_0000, analog_cfg[i]};
		end
		case (idx)
			io_param_pkg::IDX_CHANNEL_DIAG: next_rdata = {24'h00_0000, channel_diag_enables};
			io_param_pkg::IDX_WIREBREAK_DIAG: next_rdata = {24'h00_0000, wirebreak_diag_enables};
			io_param_pkg::IDX_RESERVED: next_rdata = 32'h0000_0000;
			io_param_pkg::IDX_MODULE_DIAG: next_rdata = {24'h00_0000, module_diag_alarm_enable};
			io_param_pkg::SET1_BASE + io_param_pkg::IDX_CYCLE_TIME:
				next_rdata = {24'h00_0000, analog_cycle_time};
			io_param_pkg::SET1_BASE + io_param_pkg::IDX_ANALOG4_RANGE:
				next_rdata = {24'h00_0000, analog_input4_range};
			io_param_pkg::IDX_FREQ_RESULT: next_rdata = {8'h00, FREQ_COUNT};
			io_param_pkg::IDX_PERIOD_RESULT: next_rdata = {8'h00, PERIOD_COUNT};
			io_param_pkg::IDX_STATUS: next_rdata = {28'h000_0000, 1'b0, use_three == 3'h4,
				use_three == 3'h3, FREQ_VALID};
			default: ;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN)
			RDATA <= 32'h0000_0000;
		else if (RD)
			RDATA <= next_rdata;
		else
			RDATA <= 32'h0000_0000;
	end

	// universal input decoders
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ui
			logic [1:0] gc;
			universal_input_decode #(
				.ALLOW_MEASURE(g == 2),
				.ALLOW_COUNTER(g != 3)
			) u_dec (
				.cfg(universal_cfg[g]),
				.use_mode(UI_USE[3*g +: 3]),
				.alarm_en(UI_ALARM_EN[g]),
				.edge_falling(UI_EDGE_FALLING[g]),
				.count_down(UI_COUNT_DOWN[g]),
				.gate_code(gc)
			);
		end
	endgenerate
	assign gate_code = g_ui[2].gc;
	assign use_three = UI_USE[8:6];

	// analog decoders; fourth range lives in its own byte
	assign CONTINUOUS_CONVERSION = (analog_cycle_time == io_param_pkg::CYC_CONTINUOUS);
	generate
		for (g = 0; g < 4; g++) begin : g_ai
			assign range_sel[g] = (g == 3) ? analog_input4_range[io_param_pkg::AI_RANGE_LSB +: 4]
				: analog_cfg[g][io_param_pkg::AI_RANGE_LSB +: 4];
			analog_input_decode u_dec (
				.meas_type(analog_cfg[g][io_param_pkg::AI_TYPE_LSB +: 2]),
				.cea_bit(analog_cfg[g][io_param_pkg::AI_CEA_BIT]),
				.range(range_sel[g]),
				.wirebreak_bit(wirebreak_diag_enables[g]),
				.diag_bit(channel_diag_enables[g]),
				.continuous(CONTINUOUS_CONVERSION),
				.active(AI_ACTIVE[g]),
				.diag_en(AI_DIAG_EN[g]),
				.wirebreak_en(AI_WIREBREAK_EN[g]),
				.cycle_end_en(cea[g])
			);
		end
	endgenerate
	assign CYCLE_END_ALARM_EN = |cea;
	assign AO_DIAG_EN = channel_diag_enables[4];
	assign MODULE_DIAG_ALARM_EN = module_diag_alarm_enable[0];

	// cycle time in microseconds
	always_comb begin
		if (analog_cycle_time == io_param_pkg::CYC_16MS)
			CYCLE_TIME_US = 16'(io_param_pkg::CYC_16MS_US);
		else if (analog_cycle_time == io_param_pkg::CYC_CONTINUOUS)
			CYCLE_TIME_US = 16'(io_param_pkg::CYC_CONT_US);
		else if (analog_cycle_time >= io_param_pkg::CYC_STEP_BASE)
			CYCLE_TIME_US = 16'(io_param_pkg::CYC_BASE_US) + 16'(io_param_pkg::CYC_STEP_US)
				* 16'(analog_cycle_time - io_param_pkg::CYC_STEP_BASE);
		else
			CYCLE_TIME_US = 16'(io_param_pkg::CYC_16MS_US);
	end

	// input pin synchroniser and rising edge
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN)
			pin_sync <= 3'h0;
		else
			pin_sync <= {pin_sync[1:0], UNIVERSAL_INPUT_THREE};
	end
	assign rise = pin_sync[1] && !pin_sync[2];
	assign meas_freq = (use_three == io_param_pkg::USE_FREQ);
	assign meas_period = (use_three == io_param_pkg::USE_PERIOD);

	// frequency meter
	always_comb begin
		case (gate_code)
			2'h0: gate_len = 32'(GATE_0_CYCLES);
			2'h1: gate_len = 32'(GATE_1_CYCLES);
			default: gate_len = 32'(GATE_2_CYCLES);
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN || !meas_freq) begin
			gate_cnt <= 32'h0000_0000;
			edge_cnt <= 24'h00_0000;
			FREQ_COUNT <= 24'hFF_FFFF;
			FREQ_VALID <= 1'b0;
		end else if (gate_cnt >= gate_len - 32'h0000_0001) begin
			gate_cnt <= 32'h0000_0000;
			FREQ_COUNT <= edge_cnt + {23'h00_0000, rise};
			FREQ_VALID <= 1'b1;
			edge_cnt <= 24'h00_0000;
		end else begin
			gate_cnt <= gate_cnt + 32'h0000_0001;
			if (rise && edge_cnt != 24'hFF_FFFF)
				edge_cnt <= edge_cnt + 24'h00_0001;
		end
	end

	// period counter
	always_ff @(posedge SYS_CLK) begin
		if (!RESETN || !meas_period) begin
			period_state <= io_param_pkg::MEAS_IDLE;
			tick_cnt <= '0;
			period_cnt <= 24'h00_0000;
			PERIOD_COUNT <= 24'h00_0000;
		end else begin
			case (period_state)
				io_param_pkg::MEAS_IDLE: period_state <= io_param_pkg::MEAS_ARMED;
				io_param_pkg::MEAS_ARMED: begin
					if (rise) begin
						period_state <= io_param_pkg::MEAS_RUN;
						tick_cnt <= '0;
						period_cnt <= 24'h00_0000;
					end
				end
				io_param_pkg::MEAS_RUN: begin
					if (rise) begin
						// the rise cycle closes the last tick of the period
						if (tick_cnt == $bits(tick_cnt)'(io_param_pkg::TICK_CYCLES - 1)
							&& period_cnt != 24'hFF_FFFF)
							PERIOD_COUNT <= period_cnt + 24'h00_0001;
						else
							PERIOD_COUNT <= period_cnt;
						period_cnt <= 24'h00_0000;
						tick_cnt <= '0;
					end else if (tick_cnt == $bits(tick_cnt)'(io_param_pkg::TICK_CYCLES - 1)) begin
						tick_cnt <= '0;
						if (period_cnt != 24'hFF_FFFF)
							period_cnt <= period_cnt + 24'h00_0001;
						else
							PERIOD_COUNT <= 24'hFF_FFFF;
					end else begin
						tick_cnt <= tick_cnt + 1'b1;
					end
				end
				default: period_state <= io_param_pkg::MEAS_IDLE;
			endcase
		end
	end
endmodule : io_parameter_block

// >>> io_param_pkg.sv
// constants for the analog and universal input parameter block
package io_param_pkg;
	// register indices (byte addresses = 4 * index)
	localparam logic [7:0] IDX_CHANNEL_DIAG = 8'h00;
	localparam logic [7:0] IDX_WIREBREAK_DIAG = 8'h01;
	localparam logic [7:0] IDX_RESERVED = 8'h02;
	localparam logic [7:0] IDX_MODULE_DIAG = 8'h03;
	// parameter set 1 sits above parameter set 0 (own placement)
	localparam logic [7:0] SET1_BASE = 8'h10;
	localparam logic [7:0] IDX_UNIVERSAL1 = 8'h00;
	localparam logic [7:0] IDX_CYCLE_TIME = 8'h04;
	localparam logic [7:0] IDX_ANALOG1 = 8'h05;
	localparam logic [7:0] IDX_ANALOG4_RANGE = 8'h09;
	// measurement results, read only (own placement)
	localparam logic [7:0] IDX_FREQ_RESULT = 8'h20;
	localparam logic [7:0] IDX_PERIOD_RESULT = 8'h21;
	localparam logic [7:0] IDX_STATUS = 8'h22;
	localparam int ADDR_W = 10;
	// universal input fields
	localparam int USE_LSB = 0;
	localparam int PALARM_BIT = 3;
	localparam int EDGE_BIT = 4;
	localparam int DIR_BIT = 5;
	localparam int GATE_LSB = 6;
	localparam logic [2:0] USE_PLAIN = 3'h0;
	localparam logic [2:0] USE_ALARM = 3'h1;
	localparam logic [2:0] USE_COUNTER = 3'h2;
	localparam logic [2:0] USE_FREQ = 3'h3;
	localparam logic [2:0] USE_PERIOD = 3'h4;
	// analog input fields
	localparam int AI_TYPE_LSB = 0;
	localparam int AI_CEA_BIT = 2;
	localparam int AI_RANGE_LSB = 4;
	localparam logic [1:0] AI_TYPE_OFF = 2'h0;
	localparam logic [1:0] AI_TYPE_VOLT = 2'h1;
	localparam logic [1:0] AI_TYPE_CURR = 2'h2;
	localparam logic [3:0] RANGE_LIVE_ZERO = 4'h3;
	localparam logic [3:0] RANGE_BIPOLAR_CURR = 4'h4;
	localparam logic [3:0] RANGE_BIPOLAR_VOLT = 4'h9;
	localparam logic [7:0] ANALOG_RESET = 8'h91;
	localparam logic [7:0] ZERO_RESET = 8'h00;
	// cycle time codes
	localparam logic [7:0] CYC_16MS = 8'h00;
	localparam logic [7:0] CYC_CONTINUOUS = 8'h01;
	localparam logic [7:0] CYC_STEP_BASE = 8'h06;
	localparam int CYC_16MS_US = 16000;
	localparam int CYC_CONT_US = 2500;
	localparam int CYC_BASE_US = 3000;
	localparam int CYC_STEP_US = 500;
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_NS = 500;
	localparam int TICK_CYCLES = TICK_NS * (CLK_HZ / 1_000_000) / 1000;
	localparam int GATE_0_MS = 100;
	localparam int GATE_1_MS = 1000;
	localparam int GATE_2_MS = 10000;
	localparam int GATE_0_CYCLES = GATE_0_MS * (CLK_HZ / 1000);
	localparam int GATE_1_CYCLES = GATE_1_MS * (CLK_HZ / 1000);
	localparam int GATE_2_CYCLES = GATE_2_MS * (CLK_HZ / 1000);
	localparam int FREQ_W = 24;
	localparam int PERIOD_W = 24;
	typedef enum logic [1:0] {MEAS_IDLE, MEAS_ARMED, MEAS_RUN} meas_state_t;
endpackage : io_param_pkg

// >>> universal_input_decode.sv
// decode of one universal input configuration byte
`timescale 1ns/100ps
module universal_input_decode #(
	parameter bit ALLOW_MEASURE = 1'b0,
	parameter bit ALLOW_COUNTER = 1'b1
) (
	// configuration
	input wire logic [7:0] cfg,
	// decoded controls
	output logic [2:0] use_mode,
	output logic alarm_en,
	output logic edge_falling,
	output logic count_down,
	output logic [1:0] gate_code
);
	logic [2:0] raw;
	logic legal;
	always_comb begin
		raw = cfg[io_param_pkg::USE_LSB +: 3];
		legal = (raw == io_param_pkg::USE_PLAIN) || (raw == io_param_pkg::USE_ALARM)
			|| (ALLOW_COUNTER && raw == io_param_pkg::USE_COUNTER)
			|| (ALLOW_MEASURE && (raw == io_param_pkg::USE_FREQ
			|| raw == io_param_pkg::USE_PERIOD));
		use_mode = legal ? raw : io_param_pkg::USE_PLAIN;
		case (use_mode)
			io_param_pkg::USE_ALARM: alarm_en = 1'b1;
			io_param_pkg::USE_COUNTER: alarm_en = cfg[io_param_pkg::PALARM_BIT];
			default: alarm_en = 1'b0;
		endcase
		edge_falling = cfg[io_param_pkg::EDGE_BIT] && ((use_mode == io_param_pkg::USE_ALARM)
			|| (use_mode == io_param_pkg::USE_COUNTER));
		count_down = cfg[io_param_pkg::DIR_BIT] && (use_mode == io_param_pkg::USE_COUNTER);
		gate_code = (ALLOW_MEASURE && use_mode == io_param_pkg::USE_FREQ)
			? cfg[io_param_pkg::GATE_LSB +: 2] : 2'h0;
	end
endmodule : universal_input_decode

// >>> analog_input_decode.sv
// decode of one analog input configuration
`timescale 1ns/100ps
module analog_input_decode (
	// configuration
	input wire logic [1:0] meas_type,
	input wire logic cea_bit,
	input wire logic [3:0] range,
	input wire logic wirebreak_bit,
	input wire logic diag_bit,
	input wire logic continuous,
	// decoded controls
	output logic active,
	output logic diag_en,
	output logic wirebreak_en,
	output logic cycle_end_en
);
	always_comb begin
		active = (meas_type == io_param_pkg::AI_TYPE_VOLT)
			|| (meas_type == io_param_pkg::AI_TYPE_CURR);
		diag_en = diag_bit && active;
		wirebreak_en = wirebreak_bit && active && (meas_type == io_param_pkg::AI_TYPE_CURR)
			&& (range == io_param_pkg::RANGE_LIVE_ZERO);
		cycle_end_en = cea_bit && active && !continuous;
	end
endmodule : analog_input_decode

// >>> io_parameter_block_assertions.sv
// port-level checks for the io parameter block
`timescale 1ns/100ps
module io_parameter_block_checker (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESETN,
	// register port
	input wire logic RD,
	input wire logic [31:0] RDATA,
	// decoded controls
	input wire logic [11:0] UI_USE,
	input wire logic [3:0] UI_ALARM_EN,
	input wire logic [3:0] UI_EDGE_FALLING,
	input wire logic [3:0] UI_COUNT_DOWN,
	input wire logic [3:0] AI_ACTIVE,
	input wire logic [3:0] AI_WIREBREAK_EN,
	input wire logic CYCLE_END_ALARM_EN,
	input wire logic CONTINUOUS_CONVERSION,
	input wire logic [15:0] CYCLE_TIME_US,
	// results
	input wire logic [23:0] FREQ_COUNT,
	input wire logic FREQ_VALID
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESETN);
	property p_rdata_idle;
		!RD |=> RDATA == 32'h0000_0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	property p_use_limits;
		UI_USE[2:0] <= 3'h2 && UI_USE[5:3] <= 3'h2 && UI_USE[8:6] <= 3'h4;
	endproperty
	a_use_limits: assert property (p_use_limits) else $error("use code out of range");
	property p_alarm_forced;
		UI_USE[5:3] == 3'h1 |-> UI_ALARM_EN[1];
	endproperty
	a_alarm_forced: assert property (p_alarm_forced) else $error("alarm not forced");
	property p_plain_quiet;
		UI_USE[2:0] == 3'h0 |-> !UI_ALARM_EN[0] && !UI_EDGE_FALLING[0] && !UI_COUNT_DOWN[0];
	endproperty
	a_plain_quiet: assert property (p_plain_quiet) else $error("plain use not quiet");
	property p_edge_three;
		UI_EDGE_FALLING[2] |-> UI_USE[8:6] inside {3'h1, 3'h2};
	endproperty
	a_edge_three: assert property (p_edge_three) else $error("edge outside use");
	property p_dir_counter;
		UI_COUNT_DOWN[2] |-> UI_USE[8:6] == 3'h2;
	endproperty
	a_dir_counter: assert property (p_dir_counter) else $error("direction outside counter");
	property p_input_four;
		UI_USE[11:10] == 2'h0 && UI_ALARM_EN[3] == UI_USE[9];
	endproperty
	a_input_four: assert property (p_input_four) else $error("input four decode");
	property p_wirebreak;
		(AI_WIREBREAK_EN & ~AI_ACTIVE) == 4'h0;
	endproperty
	a_wirebreak: assert property (p_wirebreak) else $error("wire-break on idle input");
	property p_continuous;
		CONTINUOUS_CONVERSION |-> !CYCLE_END_ALARM_EN && CYCLE_TIME_US == 16'h09C4;
	endproperty
	a_continuous: assert property (p_continuous) else $error("continuous decode");
	property p_cycle_end_or;
		CYCLE_END_ALARM_EN |-> AI_ACTIVE != 4'h0;
	endproperty
	a_cycle_end_or: assert property (p_cycle_end_or) else $error("cycle-end without input");
	property p_freq_marker;
		!FREQ_VALID |-> FREQ_COUNT == 24'hFF_FFFF;
	endproperty
	a_freq_marker: assert property (p_freq_marker) else $error("frequency marker missing");
	c_read: cover property (RD ##1 RDATA != 32'h0000_0000);
	c_freq: cover property ($rose(FREQ_VALID));
	c_wirebreak: cover property (AI_WIREBREAK_EN != 4'h0);
endmodule : io_parameter_block_checker

bind io_parameter_block io_parameter_block_checker io_parameter_block_checker_i (
	.SYS_CLK, .RESETN, .RD, .RDATA, .UI_USE, .UI_ALARM_EN, .UI_EDGE_FALLING, .UI_COUNT_DOWN,
	.AI_ACTIVE, .AI_WIREBREAK_EN, .CYCLE_END_ALARM_EN, .CONTINUOUS_CONVERSION, .CYCLE_TIME_US,
	.FREQ_COUNT, .FREQ_VALID
);

// >>> io_parameter_block_test.sv
// self-checking bench for the io parameter block
`timescale 1ns/100ps
module io_parameter_block_test;
	logic SYS_CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [9:0] ADDR = 10'h000;
	logic [31:0] WDATA = 32'h0000_0000;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic UNIVERSAL_INPUT_THREE = 1'b0;
	logic [31:0] RDATA;
	logic [11:0] UI_USE;
	logic [3:0] UI_ALARM_EN, UI_EDGE_FALLING, UI_COUNT_DOWN, AI_ACTIVE, AI_DIAG_EN, AI_WIREBREAK_EN;
	logic AO_DIAG_EN, MODULE_DIAG_ALARM_EN, CYCLE_END_ALARM_EN, CONTINUOUS_CONVERSION, FREQ_VALID;
	logic [15:0] CYCLE_TIME_US;
	logic [23:0] FREQ_COUNT, PERIOD_COUNT;
	logic pin_run = 1'b0;
	int per = 10;
	int pcnt = 0;
	int n_fail = 0;
	int cmp_count = 0;
	io_parameter_block #(.GATE_0_CYCLES(100), .GATE_1_CYCLES(200), .GATE_2_CYCLES(400))
	io_parameter_block_i (
		.SYS_CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .UNIVERSAL_INPUT_THREE, .UI_USE,
		.UI_ALARM_EN, .UI_EDGE_FALLING, .UI_COUNT_DOWN, .AI_ACTIVE, .AI_DIAG_EN, .AI_WIREBREAK_EN,
		.AO_DIAG_EN, .MODULE_DIAG_ALARM_EN, .CYCLE_END_ALARM_EN, .CONTINUOUS_CONVERSION,
		.CYCLE_TIME_US, .FREQ_COUNT, .FREQ_VALID, .PERIOD_COUNT
	);
	initial forever #5 SYS_CLK = ~SYS_CLK;
	// square wave on input three, period per cycles
	always @(posedge SYS_CLK) begin
		pcnt <= (pcnt >= per - 1) ? 0 : pcnt + 1;
		UNIVERSAL_INPUT_THREE <= pin_run && (pcnt < per / 2);
	end
	task wrap_up;
		if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	task check(string what, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task expire(bit ok);
		if (!ok) begin
			n_fail++;
			wrap_up();
		end
	endtask : expire
	task wr(logic [7:0] idx, logic [7:0] data);
		@(posedge SYS_CLK);
		ADDR <= {idx, 2'b00};
		WDATA <= {24'h00_0000, data};
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
		#1;
	endtask : wr
	task rd(logic [7:0] idx, logic [31:0] exp);
		@(posedge SYS_CLK);
		ADDR <= {idx, 2'b00};
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		#1;
		check($sformatf("reg %h", idx), RDATA, exp);
	endtask : rd
	task t_reset;
		for (int i = 0; i < 9; i++) rd(8'(i < 4 ? i : 8'h0C + i), 32'h0000_0000);
		for (int i = 8'h15; i < 8'h1A; i++) rd(8'(i), 32'h0000_0091);
		check("ai_active", AI_ACTIVE, 4'hF);
		check("cycle_us", CYCLE_TIME_US, 16'h3E80);
	endtask : t_reset
	task t_set0;
		static logic [7:0] exp0 [4] = '{8'h1F, 8'h0F, 8'h00, 8'h01};
		for (int i = 0; i < 4; i++) wr(8'(i), 8'hFF);
		for (int i = 0; i < 4; i++) rd(8'(i), {24'h00_0000, exp0[i]});
		check("ao_diag", AO_DIAG_EN, 1'b1);
		check("mod_diag", MODULE_DIAG_ALARM_EN, 1'b1);
		check("wb_volt", AI_WIREBREAK_EN, 4'h0);
		wr(8'h15, 8'h32);
		wr(8'h16, 8'h42);
		wr(8'h17, 8'h90);
		check("wb", AI_WIREBREAK_EN, 4'h1);
		check("diag", AI_DIAG_EN, 4'hB);
		wr(8'h30, 8'hAA);
		rd(8'h30, 32'h0000_0000);
	endtask : t_set0
	task t_universal;
		static logic [2:0] lim [4] = '{3'h2, 3'h2, 3'h4, 3'h1};
		logic [2:0] u;
		for (int n = 0; n < 4; n++) begin
			for (int c = 0; c < 5; c++) begin
				wr(8'(8'h10 + n), 8'(8'h38 + c));
				u = (c <= lim[n]) ? 3'(c) : 3'h0;
				check("use", UI_USE[3*n+:3], u);
				check("alarm", UI_ALARM_EN[n], u == 1 || u == 2);
				check("edge", UI_EDGE_FALLING[n], u == 1 || u == 2);
				check("down", UI_COUNT_DOWN[n], u == 2);
			end
		end
		wr(8'h10, 8'h02);
		check("alarm_opt", UI_ALARM_EN[0], 1'b0);
	endtask : t_universal
	task t_cycle;
		static logic [7:0] code [6] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h08, 8'h64};
		static logic [15:0] us [6] = '{16'h3E80, 16'h09C4, 16'h3E80, 16'h0BB8, 16'h0FA0, 16'hC350};
		wr(8'h16, 8'h95);
		for (int i = 0; i < 6; i++) begin
			wr(8'h14, code[i]);
			check("cycle", CYCLE_TIME_US, us[i]);
			check("cont", CONTINUOUS_CONVERSION, code[i] == 8'h01);
			check("cea", CYCLE_END_ALARM_EN, code[i] != 8'h01);
		end
		wr(8'h16, 8'h91);
		check("cea_off", CYCLE_END_ALARM_EN, 1'b0);
	endtask : t_cycle
	task t_freq;
		int i;
		pin_run = 1'b1;
		for (int g = 0; g < 3; g++) begin
			wr(8'h12, 8'h00);
			wr(8'h12, 8'(g * 64 + 3));
			check("marker", FREQ_COUNT, 24'hFF_FFFF);
			for (i = 0; i < 1000 && FREQ_VALID !== 1'b1; i++) begin
				@(posedge SYS_CLK);
				#1;
			end
			expire(i < 1000);
			check("count", FREQ_COUNT, 10 << g);
			repeat (100 << g) @(posedge SYS_CLK);
			#1;
			check("again", FREQ_COUNT, 10 << g);
			rd(8'h20, 32'(10 << g));
		end
		rd(8'h22, 32'h0000_0003);
	endtask : t_freq
	task t_period(int cycles);
		int i;
		per = cycles;
		for (i = 0; i < 2000 && PERIOD_COUNT !== 24'(cycles / 50); i++) begin
			@(posedge SYS_CLK);
			#1;
		end
		expire(i < 2000);
		check("period", PERIOD_COUNT, cycles / 50);
	endtask : t_period
	initial begin
		repeat (100000) @(posedge SYS_CLK);
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		t_reset();
		t_set0();
		t_universal();
		t_cycle();
		t_freq();
		wr(8'h12, 8'h04);
		t_period(200);
		t_period(150);
		rd(8'h22, 32'h0000_0004);
		wrap_up();
	end
endmodule : io_parameter_block_test
